// ==== core/ucm_channel_mode.sv ====
// Mode registers, queues, thresholds, watchdog and receive flow control of one channel.
// Assumes a Wishbone master on clk_i and bit-time ticks from the receiver 1X clock.
`timescale 1ns/100ps
module ucm_channel_mode
  import ucm_pkg::*;
#(
  parameter int DW = 8, // Character width
  parameter int QD = 16 // Storage depth of each queue
) (
  input wire logic clk_i, // 200 MHz clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write enable
  input wire logic [7:0] adr_i, // Wishbone byte address
  input wire logic [3:0] sel_i, // Wishbone byte selects
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  input wire logic rx_valid_i, // Receiver delivers a character
  input wire ucm_rxchar_s rx_char_i, // Received character and status
  input wire logic rx_start_i, // Receiver saw a valid start bit
  input wire logic rx_bit_tick_i, // One receiver bit time elapsed
  input wire logic tx_take_i, // Transmit shifter takes a character
  output logic [DW-1:0] tx_data_o, // Character for the shifter
  output logic tx_avail_o, // Transmit queue holds a character
  output ucm_fmt_s fmt_o, // Character format
  output logic [2:0] baud_group_o, // Baud group select
  output logic rx_irq_o, // Receive interrupt request
  output logic tx_irq_o, // Transmit interrupt request
  output logic request_to_send_out_n_o // Send request pin, active low
);
  // Threshold: bytes stored for receive, positions empty for transmit
  function automatic logic [4:0] ucm_level(input logic [1:0] code, input logic deep,
                                           input logic is_tx);
    logic [4:0] lv;
    lv = 5'd1;
    case (code)
      2'b00: lv = is_tx ? (deep ? 5'd16 : 5'd8) : 5'd1;
      2'b01: lv = is_tx ? (deep ? 5'd8 : 5'd4) : (deep ? 5'd8 : 5'd6);
      2'b10: lv = is_tx ? (deep ? 5'd12 : 5'd6) : (deep ? 5'd12 : 5'd4);
      default: lv = is_tx ? 5'd1 : (deep ? 5'd16 : 5'd8);
    endcase
    return lv;
  endfunction : ucm_level

  logic [7:0] mode_zero_fifo_baud_ff; // Mode register zero
  logic [7:0] mode_one_char_format_ff; // Mode register one
  logic [7:0] mode_reg_two_ff; // Mode register two
  ucm_ptr_e ptr_ff; // Mode register pointer
  logic ack_ff; // Registered acknowledge
  logic [31:0] rdata_ff; // Registered read data
  ucm_rxchar_s rxq [QD]; // Receive queue storage
  logic [DW-1:0] txq [QD]; // Transmit queue storage
  logic [3:0] rx_wp_ff, rx_rp_ff, tx_wp_ff, tx_rp_ff; // Queue pointers
  logic [4:0] rx_cnt_ff, tx_cnt_ff; // Queue occupancy
  logic rx_en_ff, tx_en_ff; // Receiver and transmitter enables
  logic [2:0] blk_err_ff; // Accumulated break, framing, parity
  logic ovr_ff; // Overrun flag
  logic [6:0] wd_cnt_ff; // Watchdog bit-time counter
  logic wd_flag_ff; // Watchdog alert
  logic oport0_ff; // Output port bit zero
  logic rts_hold_ff; // Flow control negation in force
  logic [DW-1:0] tx_data_ff; // Head of transmit queue
  logic tx_avail_ff, rx_irq_ff, tx_irq_ff, rts_n_ff; // Output flops

  logic req, wr, rd; // New bus request and its direction
  logic cmd_wr, data_rd, data_wr; // Decoded accesses
  logic [3:0] cmd; // Command code
  logic deep; // Depth select
  logic [4:0] depth; // Active depth
  logic rx_full, rx_push, rx_pop, rx_clr; // Receive queue control
  logic tx_push, tx_pop; // Transmit queue control
  logic [1:0] rx_code; // Receive threshold code
  logic [2:0] top_err; // Status of queue top
  logic [2:0] err_view; // Status shown to software

  // Bus decode; one request per cycle since ack drops after one cycle
  assign req = cyc_i & stb_i & ~ack_ff;
  assign wr = req & we_i & sel_i[0];
  assign rd = req & ~we_i;
  assign cmd = dat_i[7:4];
  assign cmd_wr = wr & (adr_i == UCM_OFS_CMD);
  assign data_rd = rd & (adr_i == UCM_OFS_DATA);
  assign data_wr = wr & (adr_i == UCM_OFS_DATA);
  assign deep = mode_zero_fifo_baud_ff[UCM_M0_SIZE];
  assign depth = deep ? 5'(UCM_DEPTH_LARGE) : 5'(UCM_DEPTH_SMALL);
  assign rx_clr = cmd_wr & (cmd == UCM_CMD_RX_RESET);
  assign rx_full = (rx_cnt_ff >= depth);
  assign rx_push = rx_valid_i & rx_en_ff & ~rx_full;
  assign rx_pop = data_rd & (rx_cnt_ff != 5'd0);
  assign tx_push = data_wr & (tx_cnt_ff < depth);
  assign tx_pop = tx_take_i & tx_en_ff & (tx_cnt_ff != 5'd0);
  assign rx_code = {mode_zero_fifo_baud_ff[UCM_M0_RXINT],
                    mode_one_char_format_ff[UCM_M1_RXINT]};
  assign top_err = (rx_cnt_ff != 5'd0) ?
                   {rxq[rx_rp_ff].brk, rxq[rx_rp_ff].fe, rxq[rx_rp_ff].pe} : 3'b000;
  assign err_view = mode_one_char_format_ff[UCM_M1_ERRMODE] ?
                    (blk_err_ff | top_err) : top_err;

  // Bus acknowledge, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // Read data, captured with the request; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0;
    end else if (rd) begin
      case (adr_i)
        UCM_OFS_MODE: begin
          case (ptr_ff)
            UCM_PTR_ZERO: rdata_ff <= {24'h0, mode_zero_fifo_baud_ff};
            UCM_PTR_ONE: rdata_ff <= {24'h0, mode_one_char_format_ff};
            default: rdata_ff <= {24'h0, mode_reg_two_ff};
          endcase
        end
        UCM_OFS_STATUS: begin
          rdata_ff <= {24'h0, err_view, ovr_ff, tx_cnt_ff == 5'd0,
                       tx_cnt_ff < depth, rx_full, rx_cnt_ff != 5'd0};
        end
        UCM_OFS_DATA: rdata_ff <= {24'h0, rxq[rx_rp_ff].data};
        UCM_OFS_OPORT: rdata_ff <= {31'h0, oport0_ff};
        default: rdata_ff <= 32'h0;
      endcase
    end
  end

  // Mode register writes through the pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_zero_fifo_baud_ff <= UCM_MODE_RST;
      mode_one_char_format_ff <= UCM_MODE_RST;
      mode_reg_two_ff <= UCM_MODE_RST;
    end else if (wr & (adr_i == UCM_OFS_MODE)) begin
      case (ptr_ff)
        UCM_PTR_ZERO: mode_zero_fifo_baud_ff <= dat_i[7:0];
        UCM_PTR_ONE: mode_one_char_format_ff <= dat_i[7:0];
        default: mode_reg_two_ff <= dat_i[7:0];
      endcase
    end
  end

  // Pointer: commands reposition it, mode accesses advance it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_ff <= UCM_PTR_ONE;
    end else if (cmd_wr & (cmd == UCM_CMD_PTR_ONE)) begin
      ptr_ff <= UCM_PTR_ONE;
    end else if (cmd_wr & (cmd == UCM_CMD_PTR_ZERO)) begin
      ptr_ff <= UCM_PTR_ZERO;
    end else if (req & (adr_i == UCM_OFS_MODE)) begin
      case (ptr_ff)
        UCM_PTR_ZERO: ptr_ff <= UCM_PTR_ONE;
        UCM_PTR_ONE: ptr_ff <= UCM_PTR_TWO;
        default: ptr_ff <= UCM_PTR_TWO;
      endcase
    end
  end

  // Enables from the low command bits; disable wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_en_ff <= 1'b0;
      tx_en_ff <= 1'b0;
    end else if (cmd_wr) begin
      if (dat_i[UCM_CR_RXDIS]) begin
        rx_en_ff <= 1'b0;
      end else if (dat_i[UCM_CR_RXEN]) begin
        rx_en_ff <= 1'b1;
      end
      if (dat_i[UCM_CR_TXDIS]) begin
        tx_en_ff <= 1'b0;
      end else if (dat_i[UCM_CR_TXEN]) begin
        tx_en_ff <= 1'b1;
      end
    end
  end

  // Receive queue storage
  always_ff @(posedge clk_i) begin
    if (rx_push) begin
      rxq[rx_wp_ff] <= rx_char_i;
    end
  end

  // Receive queue pointers; receiver reset empties it
  always_ff @(posedge clk_i) begin
    if (rst_i | rx_clr) begin
      rx_wp_ff <= 4'h0;
      rx_rp_ff <= 4'h0;
      rx_cnt_ff <= 5'd0;
    end else begin
      if (rx_push) begin
        rx_wp_ff <= rx_wp_ff + 4'h1;
      end
      if (rx_pop) begin
        rx_rp_ff <= rx_rp_ff + 4'h1;
      end
      rx_cnt_ff <= rx_cnt_ff + 5'(rx_push) - 5'(rx_pop);
    end
  end

  // Block error accumulation over every top character
  always_ff @(posedge clk_i) begin
    if (rst_i | rx_clr | (cmd_wr & (cmd == UCM_CMD_ERR_RESET))) begin
      blk_err_ff <= 3'b000;
    end else begin
      blk_err_ff <= blk_err_ff | top_err;
    end
  end

  // Overrun: character arriving at a full queue; set beats clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_ff <= 1'b0;
    end else if (rx_valid_i & rx_en_ff & rx_full) begin
      ovr_ff <= 1'b1;
    end else if (rx_clr | (cmd_wr & (cmd == UCM_CMD_ERR_RESET))) begin
      ovr_ff <= 1'b0;
    end
  end

  // Watchdog counts idle bit times
  always_ff @(posedge clk_i) begin
    if (rst_i | data_rd | rx_push | rx_clr) begin
      wd_cnt_ff <= 7'd0;
    end else if (rx_bit_tick_i & mode_zero_fifo_baud_ff[UCM_M0_WDOG] &
                 (rx_cnt_ff != 5'd0) & (wd_cnt_ff < 7'(UCM_WDOG_BITS))) begin
      wd_cnt_ff <= wd_cnt_ff + 7'd1;
    end
  end

  // Watchdog alert holds until the queue is touched again or the watchdog is disabled
  always_ff @(posedge clk_i) begin
    if (rst_i | data_rd | rx_push | rx_clr | ~mode_zero_fifo_baud_ff[UCM_M0_WDOG]) begin
      wd_flag_ff <= 1'b0;
    end else if (wd_cnt_ff == 7'(UCM_WDOG_BITS)) begin
      wd_flag_ff <= 1'b1;
    end
  end

  // Transmit queue storage
  always_ff @(posedge clk_i) begin
    if (tx_push) begin
      txq[tx_wp_ff] <= dat_i[DW-1:0];
    end
  end

  // Transmit queue pointers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_wp_ff <= 4'h0;
      tx_rp_ff <= 4'h0;
      tx_cnt_ff <= 5'd0;
    end else begin
      if (tx_push) begin
        tx_wp_ff <= tx_wp_ff + 4'h1;
      end
      if (tx_pop) begin
        tx_rp_ff <= tx_rp_ff + 4'h1;
      end
      tx_cnt_ff <= tx_cnt_ff + 5'(tx_push) - 5'(tx_pop);
    end
  end

  // Output port bit zero, written by software only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oport0_ff <= 1'b0;
    end else if (wr & (adr_i == UCM_OFS_OPORT)) begin
      oport0_ff <= dat_i[0];
    end
  end

  // Flow control: negate on start at full, release when space frees
  always_ff @(posedge clk_i) begin
    if (rst_i | ~mode_one_char_format_ff[UCM_M1_RXRTS]) begin
      rts_hold_ff <= 1'b0;
    end else if (rx_start_i & rx_full) begin
      rts_hold_ff <= 1'b1;
    end else if (~rx_full) begin
      rts_hold_ff <= 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_irq_ff <= 1'b0;
      tx_irq_ff <= 1'b0;
      rts_n_ff <= 1'b1;
      tx_data_ff <= '0;
      tx_avail_ff <= 1'b0;
    end else begin
      rx_irq_ff <= (rx_cnt_ff >= ucm_level(rx_code, deep, 1'b0)) | wd_flag_ff;
      tx_irq_ff <= tx_en_ff & ((depth - tx_cnt_ff) >=
                   ucm_level(mode_zero_fifo_baud_ff[5:4], deep, 1'b1));
      rts_n_ff <= ~oport0_ff | rts_hold_ff;
      tx_data_ff <= txq[tx_rp_ff];
      tx_avail_ff <= (tx_cnt_ff != 5'd0);
    end
  end

  assign dat_o = rdata_ff;
  assign ack_o = ack_ff;
  assign tx_data_o = tx_data_ff;
  assign tx_avail_o = tx_avail_ff;
  assign fmt_o = ucm_fmt_s'({mode_one_char_format_ff[4:0]});
  assign baud_group_o = mode_zero_fifo_baud_ff[2:0];
  assign rx_irq_o = rx_irq_ff;
  assign tx_irq_o = tx_irq_ff;
  assign request_to_send_out_n_o = rts_n_ff;

  // Checks
  sequence s_mode_one_touch;
    req & (adr_i == UCM_OFS_MODE) & (ptr_ff == UCM_PTR_ONE) &
    ~(cmd_wr);
  endsequence
  a_ptr_advance: assert property (@(posedge clk_i) disable iff (rst_i)
    s_mode_one_touch |=> (ptr_ff == UCM_PTR_TWO))
    else $error("pointer did not advance to mode two");
  a_ptr_sticks: assert property (@(posedge clk_i) disable iff (rst_i)
    (ptr_ff == UCM_PTR_TWO) & ~cmd_wr |=> (ptr_ff == UCM_PTR_TWO))
    else $error("pointer left mode two without command");
  a_rx_full_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_valid_i & rx_en_ff & rx_full & ~rx_pop & ~rx_clr |=> ovr_ff && $stable(rx_cnt_ff))
    else $error("character accepted into a full queue");
  a_depth_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_cnt_ff <= depth) || $past(deep))
    else $error("receive count beyond selected depth");
  a_tx_empty_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_en_ff & (mode_zero_fifo_baud_ff[5:4] == 2'b00) & ~deep & (tx_cnt_ff == 5'd1)
    & $stable(mode_zero_fifo_baud_ff) & $stable(tx_en_ff) |=> ##0 !tx_irq_o)
    else $error("transmit request with a byte loaded");
  a_rx_any_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_code == 2'b00) & (rx_cnt_ff != 5'd0) |=> rx_irq_o)
    else $error("receive request missing with data held");
  a_rts_negate: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_one_char_format_ff[UCM_M1_RXRTS] & rx_start_i & rx_full ##1
    mode_one_char_format_ff[UCM_M1_RXRTS] & rx_full |=> request_to_send_out_n_o)
    else $error("send request not negated at full queue");
  a_wdog_fire: assert property (@(posedge clk_i) disable iff (rst_i)
    (wd_cnt_ff == 7'(UCM_WDOG_BITS)) & mode_zero_fifo_baud_ff[UCM_M0_WDOG] &
    ~data_rd & ~rx_push & ~rx_clr |=> ##1 rx_irq_o)
    else $error("watchdog expiry raised no receive request");
  a_err_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_one_char_format_ff[UCM_M1_ERRMODE] & blk_err_ff[0] & ~rx_clr &
    ~(cmd_wr & (cmd == UCM_CMD_ERR_RESET)) |=> blk_err_ff[0])
    else $error("block error cleared without reset command");
  // Space in the queue lets the send request return
  sequence s_space_free;
    ~rx_full ##1 oport0_ff;
  endsequence
  a_rts_release: assert property (@(posedge clk_i) disable iff (rst_i)
    s_space_free |=> !request_to_send_out_n_o)
    else $error("send request not restored with space free");
  // Overrun holds until an error reset or receiver reset
  a_ovr_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    ovr_ff & ~rx_clr & ~(cmd_wr & (cmd == UCM_CMD_ERR_RESET)) |=> ovr_ff)
    else $error("overrun flag lost without reset");
  // Receiver reset empties the queue and clears block status
  a_rx_reset_empty: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_clr |=> (rx_cnt_ff == 5'd0) && (blk_err_ff == 3'b000))
    else $error("receiver reset left data or status");
  // Disabled watchdog never raises its alert
  a_wdog_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    ~mode_zero_fifo_baud_ff[UCM_M0_WDOG] |=> !wd_flag_ff)
    else $error("watchdog alert while disabled");
endmodule : ucm_channel_mode

// ==== core/ucm_pkg.sv ====
// Constants, field positions and carrier types for the serial channel mode block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package ucm_pkg;
  // Register byte offsets
  localparam logic [7:0] UCM_OFS_MODE = 8'h00; // Pointer-selected mode register
  localparam logic [7:0] UCM_OFS_STATUS = 8'h04; // Channel status, read only
  localparam logic [7:0] UCM_OFS_CMD = 8'h08; // Channel command, write only
  localparam logic [7:0] UCM_OFS_DATA = 8'h0c; // Receive read / transmit write
  localparam logic [7:0] UCM_OFS_OPORT = 8'h10; // Output port bit zero
  // Mode register zero fields
  localparam int UCM_M0_WDOG = 7; // Watchdog enable
  localparam int UCM_M0_RXINT = 6; // Receive threshold upper bit
  localparam int UCM_M0_TXINT = 4; // Transmit threshold low bit of pair
  localparam int UCM_M0_SIZE = 3; // Queue depth select
  // Mode register one fields
  localparam int UCM_M1_RXRTS = 7; // Receiver flow control
  localparam int UCM_M1_RXINT = 6; // Receive threshold lower bit
  localparam int UCM_M1_ERRMODE = 5; // Block error mode
  localparam int UCM_M1_PARMODE = 3; // Parity mode low bit of pair
  localparam int UCM_M1_PARTYPE = 2; // Parity type
  // Status bit positions
  localparam int UCM_SR_BRK = 7; // Received break
  localparam int UCM_SR_FE = 6; // Framing error
  localparam int UCM_SR_PE = 5; // Parity error
  localparam int UCM_SR_OVR = 4; // Overrun
  localparam int UCM_SR_TXEMT = 3; // Transmit queue empty
  localparam int UCM_SR_TXRDY = 2; // Transmit space available
  localparam int UCM_SR_RXFULL = 1; // Receive queue full
  localparam int UCM_SR_RECEIVE_READY_FLAG = 0; // Receive data present
  // Command codes in the upper nibble
  localparam logic [3:0] UCM_CMD_PTR_ONE = 4'h1; // Pointer to mode one
  localparam logic [3:0] UCM_CMD_RX_RESET = 4'h2; // Receiver reset
  localparam logic [3:0] UCM_CMD_ERR_RESET = 4'h4; // Error reset
  localparam logic [3:0] UCM_CMD_PTR_ZERO = 4'hb; // Pointer to mode zero
  localparam int UCM_CR_TXDIS = 3; // Disable transmitter
  localparam int UCM_CR_TXEN = 2; // Enable transmitter
  localparam int UCM_CR_RXDIS = 1; // Disable receiver
  localparam int UCM_CR_RXEN = 0; // Enable receiver
  // Reset values and timing
  localparam logic [7:0] UCM_MODE_RST = 8'h00; // All mode registers clear
  localparam int UCM_WDOG_BITS = 64; // Idle bit times before alert
  localparam int UCM_DEPTH_SMALL = 8; // Shallow queue depth
  localparam int UCM_DEPTH_LARGE = 16; // Deep queue depth
  // Character format towards the shifters
  typedef struct packed {
    logic [1:0] par_mode; // 00 with, 01 forced, 10 none, 11 multi-drop
    logic par_type; // Even/odd, forced value or address polarity
    logic [1:0] char_len; // 00 five .. 11 eight data bits
  } ucm_fmt_s;
  // One received character with its status
  typedef struct packed {
    logic brk; // Break seen
    logic fe; // Framing error
    logic pe; // Parity error
    logic [7:0] data; // Character
  } ucm_rxchar_s;
  // Pointer positions
  typedef enum logic [1:0] {UCM_PTR_ZERO, UCM_PTR_ONE, UCM_PTR_TWO} ucm_ptr_e;
endpackage : ucm_pkg

// ==== tb/tb.sv ====
// Self-checking bench for the channel mode block against a queue model.
// Assumes the package, the design and the remote transmitter model are compiled first.
`timescale 1ns/100ps
module tb
  import ucm_pkg::*;
;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, tx_take_i, ack_o; // Bus and control
  logic [7:0] adr_i; // Byte address
  logic [3:0] sel_i; // Byte selects
  logic [31:0] dat_i, dat_o; // Bus data
  logic rx_valid_i, rx_start_i, rx_bit_tick_i, tx_avail_o; // Serial side
  ucm_rxchar_s rx_char_i; // Received character
  logic [7:0] tx_data_o, q; // Transmit head, last read byte
  ucm_fmt_s fmt_o; // Character format
  logic [2:0] baud_group_o; // Baud group
  logic rx_irq_o, tx_irq_o, request_to_send_out_n_o; // Requests and pin
  int miscompares, checks_done, depth; // Counters
  logic [31:0] seed; // Random state
  logic [7:0] rxq[$], txq[$]; // Queue models
  int rt[2][4] = '{'{1, 6, 4, 8}, '{1, 8, 12, 16}}; // Fill thresholds
  int tt[2][4] = '{'{8, 4, 6, 1}, '{16, 8, 12, 1}}; // Empty thresholds

  ucm_channel_mode #(.DW(8), .QD(16)) ucm_channel_mode_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i),
    .rx_start_i(rx_start_i), .rx_bit_tick_i(rx_bit_tick_i), .tx_take_i(tx_take_i),
    .tx_data_o(tx_data_o), .tx_avail_o(tx_avail_o), .fmt_o(fmt_o),
    .baud_group_o(baud_group_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o),
    .request_to_send_out_n_o(request_to_send_out_n_o));
  ucm_remote_tx ucm_remote_tx_inst (.clk_i(clk_i), .rx_valid_o(rx_valid_i),
    .rx_char_o(rx_char_i), .rx_start_o(rx_start_i), .rx_bit_tick_o(rx_bit_tick_i));

  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Random source for data and modes
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Byte comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Flag comparison
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit
  // Classic single Wishbone cycle; read byte lands in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    // Wait for the answer; only the bench watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  // Program both mode registers, flush receiver, enable both directions
  task automatic cfg(input logic [7:0] m0, input logic [7:0] m1);
    bus(1'b1, UCM_OFS_CMD, {UCM_CMD_PTR_ZERO, 4'h0});
    bus(1'b1, UCM_OFS_MODE, m0);
    bus(1'b1, UCM_OFS_MODE, m1);
    bus(1'b1, UCM_OFS_CMD, {UCM_CMD_RX_RESET, 4'h0});
    bus(1'b1, UCM_OFS_CMD, {UCM_CMD_ERR_RESET, 4'h0});
    bus(1'b1, UCM_OFS_CMD, 8'h05);
    rxq.delete();
  endtask : cfg
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog against a hang
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    {rst_i, cyc_i, stb_i, we_i, tx_take_i} = 5'h10;
    {adr_i, sel_i, dat_i} = '0;
    {miscompares, checks_done} = '0;
    seed = 32'h84f7;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_bit(rx_irq_o, 1'b0);
    chk_bit(tx_irq_o, 1'b0);
    bus(1'b0, UCM_OFS_STATUS, 8'h00);
    chk(q, 8'h0c);
    // Pointer walk: mode one, then stuck at two
    bus(1'b0, UCM_OFS_MODE, 8'h00);
    chk(q, UCM_MODE_RST);
    seed = lfsr(seed);
    bus(1'b1, UCM_OFS_MODE, seed[7:0]);
    chk({3'h0, fmt_o}, 8'h00);
    bus(1'b1, UCM_OFS_CMD, {UCM_CMD_PTR_ONE, 4'h0});
    bus(1'b1, UCM_OFS_MODE, seed[7:0]);
    bus(1'b1, UCM_OFS_MODE, ~seed[7:0]);
    chk({3'h0, fmt_o}, {3'h0, seed[4:0]});
    bus(1'b1, UCM_OFS_CMD, {UCM_CMD_PTR_ONE, 4'h0});
    bus(1'b0, UCM_OFS_MODE, 8'h00);
    chk(q, seed[7:0]);
    // Every parity mode, type and length code
    for (int i = 0; i < 32; i++) begin
      bus(1'b1, UCM_OFS_CMD, {UCM_CMD_PTR_ONE, 4'h0});
      bus(1'b1, UCM_OFS_MODE, 8'(i));
      chk({3'h0, fmt_o}, 8'(i));
    end
    // Two baud groups, one and four
    foreach (rt[g]) begin
      bus(1'b1, UCM_OFS_CMD, {UCM_CMD_PTR_ZERO, 4'h0});
      bus(1'b1, UCM_OFS_MODE, g ? 8'h04 : 8'h01);
      chk({5'h0, baud_group_o}, g ? 8'h04 : 8'h01);
    end
    bus(1'b1, UCM_OFS_OPORT, 8'h01);
    // All thresholds at both depths, overrun, flow control, transmit drain
    for (int sz = 0; sz < 2; sz++) begin
      for (int c = 0; c < 4; c++) begin
        depth = sz ? UCM_DEPTH_LARGE : UCM_DEPTH_SMALL;
        cfg({1'b0, c[1], c[1:0], sz[0], 3'h0}, {1'b1, c[0], 6'h0});
        chk_bit(request_to_send_out_n_o, 1'b0);
        for (int k = 0; k <= depth; k++) begin
          seed = lfsr(seed);
          ucm_remote_tx_inst.send({3'h0, seed[7:0]});
          if (rxq.size() < depth) rxq.push_back(seed[7:0]);
          repeat (3) @(posedge clk_i);
          chk_bit(rx_irq_o, rxq.size() >= rt[sz][c]);
        end
        chk_bit(request_to_send_out_n_o, 1'b1);
        bus(1'b0, UCM_OFS_STATUS, 8'h00);
        chk(q & 8'h13, 8'h13);
        while (rxq.size() > 0) begin
          bus(1'b0, UCM_OFS_DATA, 8'h00);
          chk(q, rxq.pop_front());
          repeat (2) @(posedge clk_i);
          if (rxq.size() == depth - 1) chk_bit(request_to_send_out_n_o, 1'b0);
        end
        for (int k = 0; k < depth; k++) begin
          chk_bit(tx_irq_o, (depth - k) >= tt[sz][c]);
          seed = lfsr(seed);
          bus(1'b1, UCM_OFS_DATA, seed[7:0]);
          txq.push_back(seed[7:0]);
          @(posedge clk_i);
        end
        chk_bit(tx_irq_o, 1'b0);
        while (txq.size() > 0) begin
          chk(tx_data_o, txq.pop_front());
          chk_bit(tx_avail_o, 1'b1);
          tx_take_i <= 1'b1;
          @(posedge clk_i);
          tx_take_i <= 1'b0;
          repeat (2) @(posedge clk_i);
        end
        chk_bit(tx_irq_o, 1'b1);
        chk_bit(tx_avail_o, 1'b0);
      end
    end
    // Watchdog: restart on a new character, alert after 64 idle bit times
    cfg(8'hc8, 8'h40);
    ucm_remote_tx_inst.send({3'h0, 8'h11});
    ucm_remote_tx_inst.tick(63);
    ucm_remote_tx_inst.send({3'h0, 8'h22});
    ucm_remote_tx_inst.tick(63);
    repeat (3) @(posedge clk_i);
    chk_bit(rx_irq_o, 1'b0);
    ucm_remote_tx_inst.tick(1);
    repeat (3) @(posedge clk_i);
    chk_bit(rx_irq_o, 1'b1);
    bus(1'b0, UCM_OFS_DATA, 8'h00);
    repeat (3) @(posedge clk_i);
    chk_bit(rx_irq_o, 1'b0);
    // Character versus block error status
    for (int em = 0; em < 2; em++) begin
      cfg(8'h00, {2'h0, em[0], 5'h0});
      ucm_remote_tx_inst.send({3'h7, 8'h5a});
      ucm_remote_tx_inst.send({3'h0, 8'ha5});
      bus(1'b0, UCM_OFS_STATUS, 8'h00);
      chk(q & 8'he0, 8'he0);
      bus(1'b0, UCM_OFS_DATA, 8'h00);
      bus(1'b0, UCM_OFS_STATUS, 8'h00);
      chk(q & 8'he0, em ? 8'he0 : 8'h00);
      bus(1'b1, UCM_OFS_CMD, {UCM_CMD_ERR_RESET, 4'h0});
      bus(1'b0, UCM_OFS_STATUS, 8'h00);
      chk(q & 8'he0, 8'h00);
    end
    // Output port bit survives flow control; disabling stops transmit requests
    bus(1'b0, UCM_OFS_OPORT, 8'h00);
    chk(q, 8'h01);
    chk_bit(tx_irq_o, 1'b1);
    bus(1'b1, UCM_OFS_CMD, 8'h0a);
    chk_bit(tx_irq_o, 1'b0);
    tally_and_finish();
  end
endmodule : tb

// ==== tb/ucm_remote_tx.sv ====
// Remote serial transmitter model: start bits, characters and receiver bit ticks.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/100ps
module ucm_remote_tx
  import ucm_pkg::*;
(
  input wire logic clk_i, // Bench clock
  output logic rx_valid_o, // Character handed over
  output ucm_rxchar_s rx_char_o, // Character with status
  output logic rx_start_o, // Start bit seen
  output logic rx_bit_tick_o // One bit time elapsed
);
  // Idle line at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_char_o = '0;
    rx_start_o = 1'b0;
    rx_bit_tick_o = 1'b0;
  end
  // Start bit, then the whole character one cycle later
  task automatic send(input ucm_rxchar_s c);
    @(posedge clk_i);
    rx_start_o <= 1'b1;
    @(posedge clk_i);
    rx_start_o <= 1'b0;
    rx_valid_o <= 1'b1;
    rx_char_o <= c;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_char_o <= ~c; // Released: show the inverse, not the old value
  endtask : send
  // Bit-time pulses with a gap between them
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      rx_bit_tick_o <= 1'b1;
      @(posedge clk_i);
      rx_bit_tick_o <= 1'b0;
    end
  endtask : tick
endmodule : ucm_remote_tx
